// ==== lpp_line_pickup.sv ====
// Line pickup protection: line end open detection, close-onto-fault trip,
// reclose coordination and zone 1 extension.
// Assumes measurements and operands are produced on clk by upstream logic.
`timescale 1ns/1ps
module lpp_line_pickup #(
  parameter int TICK_CYCLES = lpp_pkg::TICK_CYCLES_DEF
) (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire lpp_pkg::lpp_cfg_s  cfg,
  input  wire lpp_pkg::lpp_meas_s measurement_source_one,
  input  wire lpp_pkg::lpp_meas_s measurement_source_two,
  input  wire lpp_pkg::lpp_opnd_s opnd,
  output lpp_pkg::lpp_out_s       status
);

  // Millisecond tick
  logic [lpp_pkg::TICK_W-1:0] tick_cnt_ff;
  logic                       tick_ff;

  // Measurement path
  lpp_pkg::lpp_meas_s         meas;
  logic                       any_oc;
  logic                       all_uc;
  logic [lpp_pkg::PROD_W-1:0] v_lhs;
  logic [lpp_pkg::PROD_W-1:0] v_rhs;
  logic                       uv;
  logic                       ov;

  // Element state
  logic                       active;
  logic                       leo_raw;
  logic                       leo;
  logic                       ov_q;
  logic                       crd_in;
  logic                       crd_q;
  logic                       fault_trip;
  logic [7:0]                 win_len;
  logic [7:0]                 win_cnt_ff;
  lpp_pkg::lpp_rcl_e          rcl_state_ff;
  lpp_pkg::lpp_rcl_e          nxt_rcl_state;
  logic                       in_window;
  logic                       rcl_trip;
  logic                       tgt_latch_ff;
  logic                       nxt_target;

  // Output registers
  logic                       leo_ff;
  logic                       ov_ff;
  logic                       operate_ff;
  logic                       rcl_trip_ff;
  logic                       target_ff;
  logic                       event_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      tick_cnt_ff <= '0;
      tick_ff     <= 1'b0;
    end else if (tick_cnt_ff == lpp_pkg::TICK_W'(TICK_CYCLES - 1)) begin
      tick_cnt_ff <= '0;
      tick_ff     <= 1'b1;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 1'b1;
      tick_ff     <= 1'b0;
    end
  end

  // Source choice between the two measurement sources
  assign meas = cfg.source_select ? measurement_source_two : measurement_source_one;

  // Function runs only when enabled and not blocked
  assign active = cfg.function_enable & ~opnd.block;

  lpp_phase_compare u_cmp (
    .meas      (meas),
    .threshold (cfg.phase_overcurrent_threshold),
    .any_over  (any_oc),
    .all_under (all_uc)
  );

  // Delta VTs: threshold base is secondary / sqrt3, so scale both sides
  always_comb begin
    if (cfg.vt_delta) begin
      v_lhs = lpp_pkg::PROD_W'(meas.v_pos) * lpp_pkg::PROD_W'(lpp_pkg::SQRT3_MILLI);
    end else begin
      v_lhs = lpp_pkg::PROD_W'(meas.v_pos) * lpp_pkg::PROD_W'(lpp_pkg::ONE_MILLI);
    end
    v_rhs = lpp_pkg::PROD_W'(cfg.undervoltage_threshold)
          * lpp_pkg::PROD_W'(lpp_pkg::ONE_MILLI);
  end

  // Same threshold serves both sides, so over and under never overlap
  assign uv = v_lhs < v_rhs;
  assign ov = ~uv;

  // Measured detection or the terminal open operand
  assign leo_raw = active & ((all_uc & uv) | opnd.terminal_open);

  lpp_delay_timer u_leo (
    .clk         (clk),
    .rst         (rst),
    .tick        (tick_ff),
    .cond        (leo_raw),
    .pickup_time (cfg.line_end_open_pickup_time),
    .reset_time  (cfg.line_end_open_reset_time),
    .q           (leo)
  );

  // Overvoltage qualified by its own pickup delay, no reset delay
  lpp_delay_timer u_ov (
    .clk         (clk),
    .rst         (rst),
    .tick        (tick_ff),
    .cond        (active & ov),
    .pickup_time (cfg.overvoltage_qualify_time),
    .reset_time  ('0),
    .q           (ov_q)
  );

  assign crd_in = active & leo & any_oc;

  // Coordination delay gives the overvoltage time to block after reclose
  lpp_delay_timer u_crd (
    .clk         (clk),
    .rst         (rst),
    .tick        (tick_ff),
    .cond        (crd_in),
    .pickup_time (cfg.reclose_coord_pickup_time),
    .reset_time  (cfg.reclose_coord_reset_time),
    .q           (crd_q)
  );

  // Skip set: instant trip. Skip clear: delayed trip unless voltage returned.
  always_comb begin
    if (cfg.reclose_coordination_skip) begin
      fault_trip = crd_in;
    end else begin
      fault_trip = crd_q & ~ov_q;
    end
  end

  // Six power cycles at the nominal frequency
  assign win_len = cfg.nominal_50hz ? lpp_pkg::WIN_MS_50HZ : lpp_pkg::WIN_MS_60HZ;

  always_comb begin
    nxt_rcl_state = rcl_state_ff;
    case (rcl_state_ff)
      lpp_pkg::LPP_RCL_IDLE: begin
        if (active & opnd.reclose_close_cmd & leo) begin
          nxt_rcl_state = lpp_pkg::LPP_RCL_WINDOW;
        end
      end
      lpp_pkg::LPP_RCL_WINDOW: begin
        if (~active | (tick_ff & (win_cnt_ff >= win_len - 8'h01))) begin
          nxt_rcl_state = lpp_pkg::LPP_RCL_IDLE;
        end
      end
      default: nxt_rcl_state = lpp_pkg::LPP_RCL_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rcl_state_ff <= lpp_pkg::LPP_RCL_IDLE;
    end else begin
      rcl_state_ff <= nxt_rcl_state;
    end
  end

  // A fresh close command restarts the window count
  always_ff @(posedge clk) begin
    if (rst) begin
      win_cnt_ff <= '0;
    end else if (rcl_state_ff == lpp_pkg::LPP_RCL_IDLE) begin
      win_cnt_ff <= '0;
    end else if (opnd.reclose_close_cmd) begin
      win_cnt_ff <= '0;
    end else if (tick_ff) begin
      win_cnt_ff <= win_cnt_ff + 8'h01;
    end
  end

  // External accelerate holds the extension open while asserted
  assign in_window = (rcl_state_ff == lpp_pkg::LPP_RCL_WINDOW)
                   | opnd.external_reclose_accelerate;

  // Zone 2 pickup or excessive current inside the window
  assign rcl_trip = active & in_window & (opnd.zone2_pickup | any_oc);

  // Set wins over a simultaneous reset of the latched target
  always_ff @(posedge clk) begin
    if (rst) begin
      tgt_latch_ff <= 1'b0;
    end else if (fault_trip | rcl_trip) begin
      tgt_latch_ff <= 1'b1;
    end else if (opnd.target_reset | (cfg.target_mode != lpp_pkg::LPP_TGT_LATCHED)) begin
      tgt_latch_ff <= 1'b0;
    end
  end

  always_comb begin
    case (cfg.target_mode)
      lpp_pkg::LPP_TGT_SELF_RESET: nxt_target = fault_trip | rcl_trip;
      lpp_pkg::LPP_TGT_LATCHED:    nxt_target = fault_trip | rcl_trip | tgt_latch_ff;
      default:                     nxt_target = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      leo_ff      <= 1'b0;
      ov_ff       <= 1'b0;
      operate_ff  <= 1'b0;
      rcl_trip_ff <= 1'b0;
      target_ff   <= 1'b0;
    end else begin
      leo_ff      <= leo;
      ov_ff       <= ov_q;
      operate_ff  <= fault_trip;
      rcl_trip_ff <= rcl_trip;
      target_ff   <= nxt_target;
    end
  end

  // Events only when recording is selected; one pulse per rising trip
  always_ff @(posedge clk) begin
    if (rst) begin
      event_ff <= 1'b0;
    end else begin
      event_ff <= cfg.events_enable
                & ((fault_trip & ~operate_ff) | (rcl_trip & ~rcl_trip_ff));
    end
  end

  assign status.line_end_open           = leo_ff;
  assign status.overvoltage_pickup      = ov_ff;
  assign status.operate                 = operate_ff;
  assign status.reclose_onto_fault_trip = rcl_trip_ff;
  assign status.target                  = target_ff;
  assign status.event_pulse             = event_ff;

endmodule

// ==== lpp_pkg.sv ====
// Constants, settings layout and operand carriers for the line pickup block.
// Assumes one 50 MHz clock; all settings are static ports held by the host logic.
package lpp_pkg;

  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_TIME_NS  = 1000000;
  localparam int TICK_CYCLES_DEF = (TICK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int CUR_W   = 15;
  localparam int VOLT_W  = 12;
  localparam int TIME_W  = 16;
  localparam int TICK_W  = 17;
  localparam int PROD_W  = 23;
  localparam int NUM_PH  = 3;

  localparam logic [CUR_W-1:0]  OC_THR_MAX   = 15'h7530;
  localparam logic [CUR_W-1:0]  OC_THR_DEF   = 15'h03E8;
  localparam logic [VOLT_W-1:0] UV_THR_MAX   = 12'hBB8;
  localparam logic [VOLT_W-1:0] UV_THR_DEF   = 12'h2BC;
  localparam logic [TIME_W-1:0] LEO_PKP_DEF  = 16'h0096;
  localparam logic [TIME_W-1:0] LEO_RST_DEF  = 16'h005A;
  localparam logic [TIME_W-1:0] OV_PKP_DEF   = 16'h0028;
  localparam logic [TIME_W-1:0] CRD_PKP_DEF  = 16'h002D;
  localparam logic [TIME_W-1:0] CRD_RST_DEF  = 16'h0005;

  // Per-unit products for the delta VT base: v * 1732 against thr * 1000
  localparam logic [10:0] SQRT3_MILLI = 11'h6C4;
  localparam logic [10:0] ONE_MILLI   = 11'h3E8;

  // Six power cycles in milliseconds at 50 Hz and 60 Hz
  localparam logic [7:0] WIN_MS_50HZ = 8'h78;
  localparam logic [7:0] WIN_MS_60HZ = 8'h64;

  typedef enum logic [1:0] {
    LPP_TGT_SELF_RESET = 2'h0,
    LPP_TGT_LATCHED    = 2'h1,
    LPP_TGT_DISABLED   = 2'h2
  } lpp_target_e;

  typedef enum logic {
    LPP_RCL_IDLE   = 1'b0,
    LPP_RCL_WINDOW = 1'b1
  } lpp_rcl_e;

  typedef struct packed {
    logic [CUR_W-1:0]  i_a;
    logic [CUR_W-1:0]  i_b;
    logic [CUR_W-1:0]  i_c;
    logic [VOLT_W-1:0] v_pos;
  } lpp_meas_s;

  typedef struct packed {
    logic              function_enable;
    logic              source_select;
    logic [CUR_W-1:0]  phase_overcurrent_threshold;
    logic [VOLT_W-1:0] undervoltage_threshold;
    logic              vt_delta;
    logic              nominal_50hz;
    logic [TIME_W-1:0] line_end_open_pickup_time;
    logic [TIME_W-1:0] line_end_open_reset_time;
    logic [TIME_W-1:0] overvoltage_qualify_time;
    logic              reclose_coordination_skip;
    logic [TIME_W-1:0] reclose_coord_pickup_time;
    logic [TIME_W-1:0] reclose_coord_reset_time;
    lpp_target_e       target_mode;
    logic              events_enable;
  } lpp_cfg_s;

  typedef struct packed {
    logic terminal_open;
    logic external_reclose_accelerate;
    logic block;
    logic reclose_close_cmd;
    logic zone2_pickup;
    logic target_reset;
  } lpp_opnd_s;

  typedef struct packed {
    logic line_end_open;
    logic overvoltage_pickup;
    logic operate;
    logic reclose_onto_fault_trip;
    logic target;
    logic event_pulse;
  } lpp_out_s;

endpackage

// ==== lpp_delay_timer.sv ====
// Pickup and reset delay timer counted in millisecond ticks.
// Assumes tick is a one-cycle pulse on the same clock; cond is synchronous.
`timescale 1ns/1ps
module lpp_delay_timer (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      tick,
  input  wire logic                      cond,
  input  wire logic [lpp_pkg::TIME_W-1:0] pickup_time,
  input  wire logic [lpp_pkg::TIME_W-1:0] reset_time,
  output logic                           q
);

  logic [lpp_pkg::TIME_W-1:0] cnt_ff;
  logic                       q_ff;
  logic [lpp_pkg::TIME_W-1:0] limit;

  assign limit = q_ff ? reset_time : pickup_time;
  assign q     = q_ff;

  // Count restarts whenever cond returns to the output state
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_ff <= '0;
      q_ff   <= 1'b0;
    end else if (cond == q_ff) begin
      cnt_ff <= '0;
    end else if (cnt_ff >= limit) begin
      q_ff   <= cond;
      cnt_ff <= '0;
    end else if (tick) begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

endmodule

// ==== lpp_phase_compare.sv ====
// Three per-phase current comparators against one threshold.
// Purely combinational; inputs come from logic on the same clock.
`timescale 1ns/1ps
module lpp_phase_compare (
  input  wire lpp_pkg::lpp_meas_s        meas,
  input  wire logic [lpp_pkg::CUR_W-1:0] threshold,
  output logic                           any_over,
  output logic                           all_under
);

  logic [lpp_pkg::NUM_PH-1:0][lpp_pkg::CUR_W-1:0] phase_i;
  logic [lpp_pkg::NUM_PH-1:0]                     over;

  assign phase_i = {meas.i_a, meas.i_b, meas.i_c};

  genvar g;
  generate
    for (g = 0; g < lpp_pkg::NUM_PH; g++) begin : g_ph
      // Instantaneous comparison, no delay of its own
      assign over[g] = phase_i[g] > threshold;
    end
  endgenerate

  assign any_over  = |over;
  assign all_under = ~|over;

endmodule

// ==== lpp_line_model.sv ====
// Line model: source one driven from bench levels, source two fixed at live levels.
// Assumes bench levels change at the falling edge; source two stays live.
`timescale 1ns/1ps
module lpp_line_model (
  input  wire logic          clk,
  input  wire logic [11:0]   volt,
  input  wire logic [14:0]   cur,
  input  wire logic          fault,
  output lpp_pkg::lpp_meas_s src_one,
  output lpp_pkg::lpp_meas_s src_two
);
  // Fault on one phase only, so a single comparator must trip alone
  always_comb begin
    src_one = '{cur, fault ? 15'h07D0 : cur, cur, volt};
    src_two = '{15'h01F4, 15'h01F4, 15'h01F4, 12'h3E8};
  end
endmodule

// ==== lpp_line_pickup_checker.sv ====
// Checker for the line pickup block, bound to its top ports.
// Assumes settings are held steady around the cycles they are used.
`timescale 1ns/1ps
module lpp_line_pickup_checker #(
  parameter int TICK_CYCLES = 4
) (
  input wire logic               clk,
  input wire logic               rst,
  input wire lpp_pkg::lpp_cfg_s  cfg,
  input wire lpp_pkg::lpp_meas_s measurement_source_one,
  input wire lpp_pkg::lpp_meas_s measurement_source_two,
  input wire lpp_pkg::lpp_opnd_s opnd,
  input wire lpp_pkg::lpp_out_s  status
);
  lpp_pkg::lpp_meas_s          m;
  logic [lpp_pkg::CUR_W-1:0]   th;
  logic                        ov;
  logic                        act;
  logic                        sr;
  assign m = cfg.source_select ? measurement_source_two : measurement_source_one;
  assign th = cfg.phase_overcurrent_threshold;
  assign ov = (m.i_a > th) | (m.i_b > th) | (m.i_c > th);
  assign act = cfg.function_enable & ~opnd.block;
  assign sr = cfg.target_mode == lpp_pkg::LPP_TGT_SELF_RESET;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_nooc; cfg.reclose_coordination_skip && !ov |=> !status.operate; endproperty
  a_nooc: assert property (p_nooc) else $error("operate without overcurrent");
  property p_off; cfg.reclose_coordination_skip && !act |=> !status.operate; endproperty
  a_off: assert property (p_off) else $error("operate while inactive");
  property p_blk; !act |=> !status.reclose_onto_fault_trip; endproperty
  a_blk: assert property (p_blk) else $error("reclose trip while inactive");
  property p_acc;
    act && opnd.external_reclose_accelerate && opnd.zone2_pickup
      |=> status.reclose_onto_fault_trip;
  endproperty
  a_acc: assert property (p_acc) else $error("accelerate gave no trip");
  property p_cause; !opnd.zone2_pickup && !ov |=> !status.reclose_onto_fault_trip; endproperty
  a_cause: assert property (p_cause) else $error("reclose trip without cause");
  property p_evt; status.event_pulse |=> !status.event_pulse; endproperty
  a_evt: assert property (p_evt) else $error("event longer than a cycle");
  property p_tdis; cfg.target_mode == lpp_pkg::LPP_TGT_DISABLED |=> !status.target; endproperty
  a_tdis: assert property (p_tdis) else $error("target while disabled");
  property p_tsr;
    sr && $past(sr) && cfg.reclose_coordination_skip
      |-> status.target == (status.operate | status.reclose_onto_fault_trip);
  endproperty
  a_tsr: assert property (p_tsr) else $error("self-reset target mismatch");
  property p_tlat;
    cfg.target_mode == lpp_pkg::LPP_TGT_LATCHED && status.target && !opnd.target_reset
      |=> status.target;
  endproperty
  a_tlat: assert property (p_tlat) else $error("latched target lost");
endmodule
bind lpp_line_pickup lpp_line_pickup_checker #(.TICK_CYCLES(TICK_CYCLES)) lpp_line_pickup_checker_i (
  .clk(clk), .rst(rst), .cfg(cfg), .measurement_source_one(measurement_source_one),
  .measurement_source_two(measurement_source_two), .opnd(opnd), .status(status));

// ==== test_lpp_line_pickup.sv ====
// Self-checking bench for the line pickup block with a line model.
// Assumes a tick of 4 clocks, so 1 ms is 4 cycles; delays scale with it.
`timescale 1ns/1ps
module test_lpp_line_pickup;
  localparam int LE = 5, OV = 4, OP = 3, RT = 2, TG = 1, EV = 0;
  logic               clk = 1'b0;
  logic               rst = 1'b1;
  lpp_pkg::lpp_cfg_s  cfg;
  lpp_pkg::lpp_opnd_s opnd = '0;
  lpp_pkg::lpp_meas_s s1, s2;
  lpp_pkg::lpp_out_s  status;
  logic [11:0]        volt = 12'h000;
  logic [14:0]        cur = 15'h0000;
  logic               fault = 1'b0;
  int                 error_cnt = 0;
  int                 num_checks = 0;
  int                 cyc = 0;
  lpp_line_pickup #(.TICK_CYCLES(4)) lpp_line_pickup_i (.clk(clk), .rst(rst), .cfg(cfg),
    .measurement_source_one(s1), .measurement_source_two(s2), .opnd(opnd), .status(status));
  lpp_line_model lpp_line_model_i (.clk(clk), .volt(volt), .cur(cur), .fault(fault),
    .src_one(s1), .src_two(s2));
  initial begin
    cfg = '{1'b0, 1'b0, lpp_pkg::OC_THR_DEF, lpp_pkg::UV_THR_DEF, 1'b0, 1'b1, 16'h0002,
      16'h000A, 16'h0000, 1'b1, 16'h0005, 16'h0001, lpp_pkg::LPP_TGT_SELF_RESET, 1'b0};
    forever #10 clk = ~clk;
  end
  // Hang guard: whole run is under two thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      finish_test();
    end
  end
  task chk(string nm, logic [31:0] got, logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task ex(string nm, int b, logic v, int n);
    for (int k = 0; k < n && status[b] !== v; k++) @(negedge clk);
    chk(nm, status[b], v);
  endtask
  task hold(string nm, int b, logic v, int n);
    repeat (n) begin
      @(negedge clk);
      chk(nm, status[b], v);
    end
  endtask
  task dead();
    volt = 12'h000;
    cur = 15'h0000;
    ex("line_end_open", LE, 1'b1, 60);
  endtask
  task live();
    fault = 1'b0;
    volt = 12'h3E8;
    cur = 15'h01F4;
    ex("line_end_open", LE, 1'b0, 80);
  endtask
  task t_open();
    live();
    dead();
    cur = 15'h0000;
    volt = 12'h3E8;
    ex("uv_needed", LE, 1'b0, 80);
    volt = 12'h1F4;
    ex("uv_wye", LE, 1'b1, 60);
    cfg.vt_delta = 1'b1;
    ex("uv_delta", LE, 1'b0, 80);
    cfg.vt_delta = 1'b0;
    live();
    opnd.terminal_open = 1'b1;
    ex("terminal_open", LE, 1'b1, 60);
    opnd.terminal_open = 1'b0;
    live();
  endtask
  task t_sotf();
    cfg.events_enable = 1'b1;
    dead();
    fault = 1'b1;
    ex("operate", OP, 1'b1, 5);
    chk("event", status[EV], 1'b1);
    chk("target", status[TG], 1'b1);
    hold("event_once", EV, 1'b0, 3);
    live();
    opnd.block = 1'b1;
    volt = 12'h000;
    cur = 15'h0000;
    hold("blocked_leo", LE, 1'b0, 40);
    opnd.block = 1'b0;
  endtask
  task t_inhibit();
    cfg.function_enable = 1'b0;
    volt = 12'h000;
    cur = 15'h0000;
    hold("disabled_leo", LE, 1'b0, 40);
    fault = 1'b1;
    hold("disabled_op", OP, 1'b0, 10);
    cfg.function_enable = 1'b1;
    opnd.block = 1'b1;
    hold("blocked_op", OP, 1'b0, 40);
    opnd.block = 1'b0;
    fault = 1'b0;
    cfg.source_select = 1'b1;
    hold("source_two", LE, 1'b0, 40);
    cfg.source_select = 1'b0;
    live();
  endtask
  task t_coord();
    cfg.reclose_coordination_skip = 1'b0;
    dead();
    chk("ov_dead", status[OV], 1'b0);
    volt = 12'h3E8;
    cur = 15'h04B0;
    hold("ov_blocks", OP, 1'b0, 40);
    chk("ov_pickup", status[OV], 1'b1);
    live();
    dead();
    fault = 1'b1;
    hold("coord_wait", OP, 1'b0, 16);
    ex("coord_trip", OP, 1'b1, 20);
    cfg.reclose_coordination_skip = 1'b1;
    live();
  endtask
  task t_rcl();
    for (int f = 1; f >= 0; f--) begin
      cfg.nominal_50hz = f[0];
      dead();
      opnd.reclose_close_cmd = 1'b1;
      @(negedge clk);
      opnd.reclose_close_cmd = 1'b0;
      hold("no_cause", RT, 1'b0, 440);
      opnd.zone2_pickup = 1'b1;
      repeat (2) @(negedge clk);
      chk("six_cycles", status[RT], f[0]);
      opnd.zone2_pickup = 1'b0;
    end
    live();
    opnd.zone2_pickup = 1'b1;
    opnd.external_reclose_accelerate = 1'b1;
    ex("accelerate", RT, 1'b1, 5);
    opnd.external_reclose_accelerate = 1'b0;
    ex("accel_off", RT, 1'b0, 5);
    opnd.zone2_pickup = 1'b0;
  endtask
  task t_target();
    cfg.target_mode = lpp_pkg::LPP_TGT_LATCHED;
    dead();
    fault = 1'b1;
    ex("op_latch", OP, 1'b1, 5);
    fault = 1'b0;
    hold("latched", TG, 1'b1, 5);
    opnd.target_reset = 1'b1;
    ex("cleared", TG, 1'b0, 5);
    opnd.target_reset = 1'b0;
    cfg.target_mode = lpp_pkg::LPP_TGT_DISABLED;
    cfg.events_enable = 1'b0;
    fault = 1'b1;
    ex("op_dis", OP, 1'b1, 5);
    chk("event_off", status[EV], 1'b0);
    hold("no_target", TG, 1'b0, 3);
    cfg.target_mode = lpp_pkg::LPP_TGT_SELF_RESET;
    live();
  endtask
  task finish_test();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(negedge clk);
    chk("reset_status", status, 6'h00);
    rst = 1'b0;
    cfg.function_enable = 1'b1;
    t_open();
    t_sotf();
    t_inhibit();
    t_coord();
    t_rcl();
    t_target();
    finish_test();
  end
endmodule
